// *** hw/ebra_pkg.sv ***
package ebra_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CS_W = 8;
  localparam int MSTP_W = 24;
  localparam logic [MSTP_W-1:0] MSTP_ALL_STOP = 24'hFFFFFF;
  localparam int SYNC_STAGES = 2;
  localparam int MASTER_CNT = 3;
  localparam int IDX_CPU = 0;
  localparam int IDX_DMA = 1;
  localparam int IDX_DTC = 2;

  typedef enum logic [1:0] {
    EBRA_DMA_MODE_SINGLE,
    EBRA_DMA_MODE_BLOCK,
    EBRA_DMA_MODE_BURST
  } ebra_dma_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic data_oe;
    logic [CS_W-1:0] chip_select_n;
    logic address_strobe_n;
    logic read_strobe_n;
    logic upper_byte_write_strobe_n;
    logic lower_byte_write_strobe_n;
  } ebra_pins_t;

  // per-master request qualifiers
  typedef struct packed {
    logic req;
    logic ext;
    logic split_mid;
    logic unit_done;
  } ebra_mreq_t;

endpackage

// *** hw/ebra_sync.sv ***
`timescale 1ns/1ps
module ebra_sync
  import ebra_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // level in and out
  input wire logic d,
  output logic q
);
  logic [SYNC_STAGES-1:0] sh_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sh_q <= {SYNC_STAGES{1'b1}};
    else
      sh_q <= {sh_q[SYNC_STAGES-2:0], d};
  end

  assign q = sh_q[SYNC_STAGES-1];
endmodule // ebra_sync

// *** hw/ebra_prio.sv ***
`timescale 1ns/1ps
module ebra_prio
  import ebra_pkg::*;
#(
  parameter bit DMA_OVER_DTC = 1'b1
)
(
  // requests, cpu at index 0
  input wire logic [MASTER_CNT-1:0] req,
  // one-hot winner
  output logic [MASTER_CNT-1:0] win
);
  // fixed order, cpu always last
  assign win = DMA_OVER_DTC ?
    (req[IDX_DMA] ? 3'h2 : req[IDX_DTC] ? 3'h4 : req[IDX_CPU] ? 3'h1 : 3'h0) :
    (req[IDX_DTC] ? 3'h4 : req[IDX_DMA] ? 3'h2 : req[IDX_CPU] ? 3'h1 : 3'h0);
endmodule // ebra_prio

// *** hw/ebra_arbiter.sv ***
`timescale 1ns/1ps
// What this block does
// - release only in expansion mode with bus_release_enable_bit set.
// - after sampling request low, drive acknowledge low and float bus pins.
// - released state floats address, data, chip selects and all strobes.
// - internal-only accesses keep running during release.
// - internal external-access is held off until request goes high.
// - request high drives acknowledge high and resumes bus control.
// - external release beats a simultaneous internal external access.
// - release stops in sleep when module_stop_ctrl is all ones.
// - each master has its own request and acknowledge.
// - only highest-priority requester acknowledged; it keeps bus until withdrawn or its yield boundary.
// - internal-bus access and external release run in parallel.
// - cpu lowest; when awake yields only between cycles, never inside split longword.
// - cpu in sleep yields the bus at once.
// - transfer controller yields only at its unit boundaries.
// - dma yields after each single transfer in single modes.
// - dma block mode yields per block, burst mode at transfer end.
// - release waits for end of current external cycle.
// - power-on reset enters reset at once, abandoning any cycle.
// - manual reset keeps state, finishes external cycle, ignores wait.
module ebra_arbiter
  import ebra_pkg::*;
#(
  parameter bit DMA_OVER_DTC = 1'b1
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic manual_reset,
  // configuration and power state
  input wire logic ext_expansion_mode,
  input wire logic bus_release_enable_bit,
  input wire logic [ebra_pkg::MSTP_W-1:0] module_stop_ctrl,
  input wire logic sleep_mode,
  input wire logic wait_n,
  // internal masters
  input wire ebra_pkg::ebra_mreq_t cpu_req,
  input wire ebra_pkg::ebra_mreq_t dma_req,
  input wire ebra_pkg::ebra_mreq_t dtc_req,
  input wire ebra_pkg::ebra_dma_mode_t dma_mode,
  output logic cpu_ack,
  output logic dma_ack,
  output logic dtc_ack,
  output logic ext_cycle_go,
  // bus controller side
  input wire logic ext_cycle_busy,
  input wire ebra_pkg::ebra_pins_t bus_pins_in,
  // external pins
  input wire logic ext_bus_request_n,
  output logic bus_ack_n,
  output logic bus_released,
  output ebra_pkg::ebra_pins_t pins_out,
  output logic [ebra_pkg::ADDR_W-1:0] addr_oe,
  output logic [ebra_pkg::DATA_W-1:0] data_oe,
  output logic ctrl_oe,
  output logic wait_honoured
);
  import ebra_pkg::*;

  typedef enum logic [1:0] {
    EBRA_OWN,
    EBRA_DRAIN,
    EBRA_RELEASED
  } ebra_state_t;

  ebra_state_t state_q, state_d;
  logic req_sync;
  logic [MASTER_CNT-1:0] req_vec, win, owner_q, owner_d;
  logic [MASTER_CNT-1:0] cur_req;
  logic [MASTER_CNT-1:0] ext_vec;
  logic ext_wanted;
  logic rel_allowed, want_rel, owner_yield, dma_yield, cpu_yield;
  logic ext_blocked;
  logic bus_ack_n_q, released_q, ext_go_q, wait_hon_q;
  logic [ADDR_W-1:0] addr_oe_q;
  logic [DATA_W-1:0] data_oe_q;
  logic ctrl_oe_q;
  ebra_pins_t pins_q;

  ebra_sync u_req_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(ext_bus_request_n),
    .q(req_sync)
  );

  // all-ones stop word in sleep kills the release path
  assign rel_allowed = ext_expansion_mode && bus_release_enable_bit
    && !(sleep_mode && module_stop_ctrl == MSTP_ALL_STOP);
  assign want_rel = rel_allowed && !req_sync;

  assign req_vec[IDX_CPU] = cpu_req.req;
  assign req_vec[IDX_DMA] = dma_req.req;
  assign req_vec[IDX_DTC] = dtc_req.req;
  assign cur_req = owner_q & req_vec;
  assign ext_vec[IDX_CPU] = cpu_req.ext;
  assign ext_vec[IDX_DMA] = dma_req.ext;
  assign ext_vec[IDX_DTC] = dtc_req.ext;
  // only the next owner's external access is started
  assign ext_wanted = |(owner_d & ext_vec);

  ebra_prio #(
    .DMA_OVER_DTC(DMA_OVER_DTC)
  ) u_prio (
    .req(req_vec),
    .win(win)
  );

  // cpu yields between cycles, or at once when asleep
  assign cpu_yield = sleep_mode || !cpu_req.split_mid;
  // single and block: yield at unit end; burst: only when request drops
  assign dma_yield = (dma_mode == EBRA_DMA_MODE_BURST) ? 1'b0 : dma_req.unit_done;
  assign owner_yield = (cur_req == '0)
    || (owner_q[IDX_CPU] && cpu_yield)
    || (owner_q[IDX_DMA] && dma_yield)
    || (owner_q[IDX_DTC] && dtc_req.unit_done);

  // keep owner until its boundary; higher master only then
  assign owner_d = owner_yield ? win : owner_q;

  // released or releasing bus blocks external starts
  assign ext_blocked = (state_q != EBRA_OWN) || want_rel;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      EBRA_OWN:
        if (want_rel)
          state_d = ext_cycle_busy ? EBRA_DRAIN : EBRA_RELEASED;
      EBRA_DRAIN:
        if (!ext_cycle_busy)
          state_d = want_rel ? EBRA_RELEASED : EBRA_OWN;
      EBRA_RELEASED:
        if (!want_rel)
          state_d = EBRA_OWN;
      default:
        state_d = EBRA_OWN;
    endcase
  end

  // power-on reset abandons everything at once
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= EBRA_OWN;
      owner_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      owner_q <= manual_reset ? owner_q : owner_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_ack_n_q <= 1'b1;
      released_q <= 1'b0;
      ext_go_q <= 1'b0;
      wait_hon_q <= 1'b0;
    end
    else
    begin
      bus_ack_n_q <= (state_d != EBRA_RELEASED);
      released_q <= (state_d == EBRA_RELEASED);
      // internal-bus accesses never wait for the release
      ext_go_q <= ext_wanted && !ext_blocked && !manual_reset && !ext_cycle_busy;
      wait_hon_q <= !manual_reset && !wait_n;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_oe_q <= '0;
      data_oe_q <= '0;
      ctrl_oe_q <= 1'b0;
      pins_q <= '0;
    end
    else
    begin
      // chip select may go straight from low to float
      addr_oe_q <= {ADDR_W{state_d != EBRA_RELEASED}};
      data_oe_q <= {DATA_W{state_d != EBRA_RELEASED && bus_pins_in.data_oe}};
      ctrl_oe_q <= (state_d != EBRA_RELEASED);
      pins_q <= bus_pins_in;
    end
  end

  // acknowledges registered; cpu and others never both granted
  logic [MASTER_CNT-1:0] ack_q;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ack_q <= '0;
    else
      ack_q <= manual_reset ? ack_q : owner_d;
  end

  assign cpu_ack = ack_q[IDX_CPU];
  assign dma_ack = ack_q[IDX_DMA];
  assign dtc_ack = ack_q[IDX_DTC];
  assign ext_cycle_go = ext_go_q;
  assign bus_ack_n = bus_ack_n_q;
  assign bus_released = released_q;
  assign pins_out = pins_q;
  assign addr_oe = addr_oe_q;
  assign data_oe = data_oe_q;
  assign ctrl_oe = ctrl_oe_q;
  assign wait_honoured = wait_hon_q;
endmodule // ebra_arbiter

// *** verif/ebra_props.sv ***
`timescale 1ns/1ps
module ebra_props
  import ebra_pkg::*;
(
  // clock and controls
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic manual_reset,
  input wire logic ext_expansion_mode,
  input wire logic bus_release_enable_bit,
  input wire logic [ebra_pkg::MSTP_W-1:0] module_stop_ctrl,
  input wire logic sleep_mode,
  input wire logic ext_cycle_busy,
  // watched pins and acks
  input wire logic ext_bus_request_n,
  input wire logic bus_ack_n,
  input wire logic bus_released,
  input wire logic [ebra_pkg::ADDR_W-1:0] addr_oe,
  input wire logic ctrl_oe,
  input wire logic cpu_ack,
  input wire logic dma_ack,
  input wire logic dtc_ack,
  input wire logic ext_cycle_go
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // five samples: request seen, two sync flops, registered answer on the fourth, one spare
  wire rel_ok = ext_expansion_mode && bus_release_enable_bit && !manual_reset && !ext_cycle_busy
    && !(sleep_mode && module_stop_ctrl == MSTP_ALL_STOP);
  AST_NOT_ENABLED: assert property (!bus_release_enable_bit && bus_ack_n |=> bus_ack_n)
    else $error("release granted while disabled");
  AST_GRANT: assert property ((!ext_bus_request_n && rel_ok)[*5] |-> !bus_ack_n)
    else $error("request not acknowledged in time");
  AST_RELEASE_END: assert property ($rose(ext_bus_request_n) && !bus_ack_n && !manual_reset |-> ##[2:4] bus_ack_n)
    else $error("release not ended after request rose");
  AST_FLOAT: assert property (!bus_ack_n |-> bus_released && addr_oe == '0 && !ctrl_oe)
    else $error("pins driven while released");
  AST_ONE_OWNER: assert property ($onehot0({cpu_ack, dma_ack, dtc_ack}))
    else $error("more than one master acknowledged");
  AST_NO_EXT_GO: assert property (!bus_ack_n |-> !ext_cycle_go)
    else $error("external cycle started while released");
  AST_BUSY_HOLD: assert property (ext_cycle_busy && bus_ack_n |=> bus_ack_n)
    else $error("released during external cycle");
  AST_MANUAL_FREEZE: assert property (manual_reset |=> $stable({cpu_ack, dma_ack, dtc_ack}))
    else $error("owner changed in manual reset");
endmodule // ebra_props

bind ebra_arbiter ebra_props u_props (.*);

// *** verif/ebra_ext_master.sv ***
`timescale 1ns/1ps
module ebra_ext_master
(
  // clock and intent
  input wire logic sys_clk,
  input wire logic want,
  // bus pins
  input wire logic bus_ack_n,
  output logic ext_bus_request_n
);
  // held low for as long as the bus is wanted, granted or not
  // follows want directly, so no race with the bench's falling edge
  always_comb
    ext_bus_request_n = !want;
endmodule // ebra_ext_master

// *** verif/ebra_arbiter_tb.sv ***
`timescale 1ns/1ps
module ebra_arbiter_tb;
  import ebra_pkg::*;
  logic sys_clk, resetn, manual_reset, ext_expansion_mode, bus_release_enable_bit, sleep_mode, wait_n, want;
  logic cpu_ack, dma_ack, dtc_ack, ext_cycle_go, ext_cycle_busy, ext_bus_request_n, bus_ack_n;
  logic bus_released, ctrl_oe, wait_honoured;
  logic [MSTP_W-1:0] module_stop_ctrl;
  logic [ADDR_W-1:0] addr_oe;
  logic [DATA_W-1:0] data_oe;
  ebra_mreq_t cpu_req, dma_req, dtc_req;
  ebra_dma_mode_t dma_mode;
  ebra_pins_t bus_pins_in, pins_out;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  ebra_arbiter uut (.*);
  ebra_ext_master ext (.sys_clk(sys_clk), .want(want), .bus_ack_n(bus_ack_n), .ext_bus_request_n(ext_bus_request_n));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // bounded: a lost answer shows up as a mismatch, not a hang
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 12 && bus_ack_n !== v; i++) tick(1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic t_refuse();
    ext_expansion_mode = 1'b0;
    want = 1'b1;
    tick(8);
    chk("ack_mode", bus_ack_n, 1'h1);
    ext_expansion_mode = 1'b1;
    bus_release_enable_bit = 1'b0;
    tick(8);
    chk("ack_off", bus_ack_n, 1'h1);
    bus_release_enable_bit = 1'b1;
    sleep_mode = 1'b1;
    module_stop_ctrl = MSTP_ALL_STOP;
    tick(8);
    chk("ack_stop", bus_ack_n, 1'h1);
    want = 1'b0;
    sleep_mode = 1'b0;
    module_stop_ctrl = 24'h000000;
    tick(6);
  endtask
  task automatic t_release();
    want = 1'b1;
    ext_cycle_busy = 1'b1;
    bus_pins_in.data_oe = 1'b1;
    tick(6);
    chk("ack_busy", bus_ack_n, 1'h1);
    chk("d_oe_own", data_oe, 16'hFFFF);
    chk("pins_copy", pins_out.data_oe, 1'h1);
    ext_cycle_busy = 1'b0;
    wait_ack(1'b0);
    chk("ack_low", bus_ack_n, 1'h0);
    chk("rel", bus_released, 1'h1);
    chk("d_oe", data_oe, 16'h0000);
    chk("a_oe", addr_oe, 24'h000000);
    cpu_req = 4'h8;
    tick(3);
    chk("int_ack", cpu_ack, 1'h1);
    cpu_req = 4'hC;
    tick(3);
    chk("go_held", ext_cycle_go, 1'h0);
    want = 1'b0;
    wait_ack(1'b1);
    tick(1);
    chk("c_oe", ctrl_oe, 1'h1);
    chk("a_oe_back", addr_oe, 24'hFFFFFF);
    chk("go_resume", ext_cycle_go, 1'h1);
    cpu_req = 4'h0;
    bus_pins_in.data_oe = 1'b0;
    tick(1);
  endtask
  task automatic t_prio();
    cpu_req = 4'hA;
    tick(2);
    chk("cpu", cpu_ack, 1'h1);
    dma_req = 4'h8;
    dtc_req = 4'h8;
    tick(3);
    chk("split", cpu_ack, 1'h1);
    cpu_req = 4'h8;
    tick(3);
    chk("dma_win", dma_ack, 1'h1);
    dma_req = 4'h0;
    tick(3);
    chk("dtc_next", dtc_ack, 1'h1);
    dma_req = 4'h8;
    tick(3);
    chk("dtc_keep", dtc_ack, 1'h1);
    dtc_req = 4'h9;
    tick(1);
    dtc_req = 4'h8;
    tick(3);
    chk("dtc_yield", dma_ack, 1'h1);
    dma_mode = EBRA_DMA_MODE_BURST;
    dma_req = 4'h9;
    tick(3);
    chk("burst", dma_ack, 1'h1);
    manual_reset = 1'b1;
    wait_n = 1'b0;
    dma_req = 4'h0;
    tick(3);
    chk("frozen", dma_ack, 1'h1);
    chk("wait_ign", wait_honoured, 1'h0);
    manual_reset = 1'b0;
    tick(3);
    chk("wait_on", wait_honoured, 1'h1);
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      finish_test();
    end
  end
  initial
  begin
    {resetn, manual_reset, sleep_mode, want, ext_cycle_busy} = 5'h00;
    {ext_expansion_mode, bus_release_enable_bit, wait_n} = 3'h7;
    module_stop_ctrl = 24'h000000;
    {cpu_req, dma_req, dtc_req} = 12'h000;
    dma_mode = EBRA_DMA_MODE_SINGLE;
    bus_pins_in = '0;
    tick(20);
    chk("rst_ack", bus_ack_n, 1'h1);
    resetn = 1'b1;
    tick(2);
    t_refuse();
    t_release();
    t_prio();
    finish_test();
  end
endmodule // ebra_arbiter_tb
